/* logic/hbcs_device.sv */
// Boot and configuration sequencer of the hub.
// Assumes the host end keeps off the bus until busReady is high.
`timescale 1ns/100ps
module hbcs_device
  import hbcs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic resetInN,
  input wire logic refClkPresent,
  input wire logic [1:0] cfgSel,
  input wire logic vbusDetect,
  input wire logic attachRequest,
  input wire logic softDisconnect,
  input wire logic usbSuspend,
  input wire logic chgDetDone,
  input wire logic eepromDone,
  hbcs_if.device bus,
  output hbcs_stage_t stage,
  output logic regulatorOn,
  output logic pllRun,
  output logic selfPowered,
  output logic eepromLoad,
  output logic chgDetStart,
  output logic [7:0] appliedCtrl
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  hbcs_stage_t next_stage;
  hbcs_method_t method;
  logic [7:0] ctrlReg;
  logic [CNT_W-1:0] waitCnt;
  logic awakeAtSuspend;
  logic serveBus;
  logic busSeen;
  logic cfgOpen;
  logic waitDone;

  // ----------------------------------------
  // Decodes and bus service
  // ----------------------------------------
  assign waitDone = (waitCnt == '0);
  // Configuration writes only before attach
  assign cfgOpen = (stage == HBCS_EXT_SETUP); // RULE21
  // Bus service blocked in init and in suspend unless kept awake
  assign serveBus = (stage != HBCS_STANDBY) && (stage != HBCS_HARDWARE_INIT_STAGE) && // RULE4
    (stage != HBCS_FW_INIT) && ((stage != HBCS_SUSPEND) || awakeAtSuspend); // RULE16 RULE17
  assign bus.busReady = serveBus;
  assign bus.wrAck = serveBus && bus.wrValid;
  // Pull-ups overcome pull-downs
  assign busSeen = bus.sdaIn && bus.sclIn; // RULE7

  // ----------------------------------------
  // Stage sequencing
  // ----------------------------------------
  // Next stage
  always_comb begin
    next_stage = stage;
    unique case (stage)
      HBCS_STANDBY: next_stage = HBCS_HARDWARE_INIT_STAGE; // RULE2
      // PLL already running before firmware init starts
      HBCS_HARDWARE_INIT_STAGE: if (waitDone && refClkPresent && pllRun) next_stage = HBCS_FW_INIT; // RULE5 RULE2
      HBCS_FW_INIT: begin
        if (method == HBCS_M_EEPROM) next_stage = HBCS_MERGE; // RULE6 RULE19
        else if (method == HBCS_M_BAD) next_stage = HBCS_INVALID; // RULE20
        else if (waitDone) next_stage = busSeen ? HBCS_EXT_SETUP : HBCS_MERGE; // RULE7 RULE22
      end
      // No timeout while waiting for the host
      HBCS_EXT_SETUP: if (bus.wrValid && bus.wrAddr == CONFIG_DONE_TRIGGER) next_stage = HBCS_MERGE; // RULE8
      HBCS_MERGE: if (!eepromLoad || eepromDone) next_stage = HBCS_IDLE; // RULE9
      HBCS_IDLE, HBCS_SUSPEND: begin
        if (vbusDetect || attachRequest) next_stage = ctrlReg[CTRL_UP_CHG_EN] ? HBCS_CHG_DET : HBCS_ATTACH; // RULE11
        else next_stage = HBCS_SUSPEND; // RULE10
      end
      HBCS_CHG_DET: begin
        if (!ctrlReg[CTRL_CHG_DET_EN] || chgDetDone) next_stage = HBCS_ATTACH; // RULE12 RULE13
      end
      HBCS_ATTACH: if (!softDisconnect) next_stage = HBCS_NORMAL; // RULE13 RULE15
      HBCS_NORMAL: begin
        if (softDisconnect) next_stage = HBCS_ATTACH; // RULE15
        else if (usbSuspend && !vbusDetect) next_stage = HBCS_SUSPEND; // RULE14
      end
      HBCS_INVALID: next_stage = HBCS_INVALID;
      default: next_stage = HBCS_STANDBY;
    endcase
  end

  // ----------------------------------------
  // Stage register
  // ----------------------------------------
  // Stage register; reset pin low forces standby
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage <= HBCS_STANDBY;
    end else if (clkEn) begin
      if (!resetInN) stage <= HBCS_STANDBY; // RULE1 RULE14
      else stage <= next_stage;
    end
  end

  // ----------------------------------------
  // Wait counter
  // ----------------------------------------
  // One counter for the settle and sense waits
  always_ff @(posedge mclk) begin
    if (srst) begin
      waitCnt <= CNT_W'(SETTLE_CYC);
    end else if (clkEn) begin
      if (stage == HBCS_STANDBY) waitCnt <= CNT_W'(SETTLE_CYC); // RULE2
      else if (stage == HBCS_HARDWARE_INIT_STAGE && next_stage == HBCS_FW_INIT) waitCnt <= CNT_W'(SENSE_CYC);
      else if (!waitDone) waitCnt <= waitCnt - 1'b1;
    end
  end

  // ----------------------------------------
  // Strap latch
  // ----------------------------------------
  // Straps latched and defaults loaded in hardware init
  always_ff @(posedge mclk) begin
    if (srst) begin
      method <= HBCS_M_SELF;
      selfPowered <= 1'b1;
    end else if (clkEn && stage == HBCS_HARDWARE_INIT_STAGE) begin
      method <= hbcs_decode(cfgSel, bus.sdaIn); // RULE3
      selfPowered <= (cfgSel != SEL_BUS_PWR); // RULE18
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Control register: defaults, host writes while open
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlReg <= CTRL_RESET;
    end else if (clkEn) begin
      if (stage == HBCS_STANDBY || stage == HBCS_HARDWARE_INIT_STAGE) ctrlReg <= CTRL_RESET; // RULE1 RULE3
      else if (cfgOpen && bus.wrValid && bus.wrAddr == CTRL_REG) ctrlReg <= bus.wrData; // RULE21
      else if (serveBus && stage != HBCS_SUSPEND && bus.wrValid && bus.wrAddr == CTRL_REG)
        ctrlReg[CTRL_KEEP_AWAKE] <= bus.wrData[CTRL_KEEP_AWAKE]; // RULE17
    end
  end

  // ----------------------------------------
  // Keep-awake capture
  // ----------------------------------------
  // Keep-awake captured on entry to suspend
  always_ff @(posedge mclk) begin
    if (srst) begin
      awakeAtSuspend <= 1'b0;
    end else if (clkEn && stage != HBCS_SUSPEND) begin
      awakeAtSuspend <= ctrlReg[CTRL_KEEP_AWAKE]; // RULE16 RULE17
    end
  end

  // ----------------------------------------
  // Applied configuration
  // ----------------------------------------
  // Merged configuration applied
  always_ff @(posedge mclk) begin
    if (srst) begin
      appliedCtrl <= 8'h00;
    end else if (clkEn) begin
      if (stage == HBCS_STANDBY) appliedCtrl <= 8'h00;
      else if (stage == HBCS_MERGE && next_stage == HBCS_IDLE) appliedCtrl <= ctrlReg; // RULE9
    end
  end

  // ----------------------------------------
  // Power controls
  // ----------------------------------------
  // Regulator follows the reset pin; PLL also needs the reference clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      regulatorOn <= 1'b0;
      pllRun <= 1'b0;
    end else if (clkEn) begin
      regulatorOn <= resetInN && stage != HBCS_STANDBY; // RULE1 RULE2
      // Clock stops in suspend unless kept awake
      pllRun <= resetInN && stage != HBCS_STANDBY && refClkPresent && !(stage == HBCS_SUSPEND && !awakeAtSuspend);
    end
  end

  // ----------------------------------------
  // EEPROM load
  // ----------------------------------------
  // Load request held through the merge stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      eepromLoad <= 1'b0;
    end else if (clkEn) begin
      eepromLoad <= (next_stage == HBCS_MERGE) && (method == HBCS_M_EEPROM); // RULE6
    end
  end

  // ----------------------------------------
  // Charger detection
  // ----------------------------------------
  // Detection started only when enabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      chgDetStart <= 1'b0;
    end else if (clkEn) begin
      chgDetStart <= (next_stage == HBCS_CHG_DET) && ctrlReg[CTRL_CHG_DET_EN]; // RULE12
    end
  end

  // ----------------------------------------
  // Bus sense pull-downs
  // ----------------------------------------
  // Weak pull-downs while sensing for a bus
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus.devSdaPullOe <= 1'b0;
      bus.devSclPullOe <= 1'b0;
    end else if (clkEn) begin
      bus.devSdaPullOe <= (stage == HBCS_FW_INIT) && (method != HBCS_M_EEPROM); // RULE7
      bus.devSclPullOe <= (stage == HBCS_FW_INIT) && (method != HBCS_M_EEPROM);
    end
  end

endmodule

/* logic/hbcs_pkg.sv */
// Package for the hub boot configuration sequencer: stages, straps, timings.
// Assumes both ends run on one clock, mclk, at 250 MHz.
// Summary of operation
// [RULE1] Reset low: standby, regulators and PLL off
// [RULE2] Reset release: hardware init, regulator, PLL lock
// [RULE3] Hardware init loads defaults, latches strap levels
// [RULE4] No bus service in hardware init
// [RULE5] Leave hardware init only with reference clock
// [RULE6] EEPROM straps: load EEPROM in merge stage
// [RULE7] Else pull lines low; pull-ups mean bus present
// [RULE8] Wait forever until host writes address 0xff
// [RULE9] Merge defaults, host and OTP settings, apply
// [RULE10] Configured: idle, suspend without VBUS or attach
// [RULE11] VBUS: charger detect if enabled, else attach
// [RULE12] Charger detect disabled: leave detect stage immediately
// [RULE13] Detection done: attach, then normal operation
// [RULE14] Stay normal; reset low returns to standby
// [RULE15] Soft disconnect holds attach stage until released
// [RULE16] No bus service in suspend unless awake
// [RULE17] Keep-awake set before suspend keeps bus service
// [RULE18] Straps 00 self powered, 10 bus powered
// [RULE19] Straps 11 with data high: EEPROM load
// [RULE20] Straps 01 data high: host; low invalid
// [RULE21] Bus configuration writes only before attach
// [RULE22] No bus, no EEPROM: merge using defaults
package hbcs_pkg;

  // Sequencer stages, Gray codes along the boot path
  typedef enum logic [3:0] {
    HBCS_STANDBY = 4'h0,
    HBCS_HARDWARE_INIT_STAGE = 4'h1,
    HBCS_FW_INIT = 4'h3,
    HBCS_EXT_SETUP = 4'h2,
    HBCS_MERGE = 4'h6,
    HBCS_IDLE = 4'h7,
    HBCS_SUSPEND = 4'h5,
    HBCS_CHG_DET = 4'h4,
    HBCS_ATTACH = 4'hc,
    HBCS_NORMAL = 4'hd,
    HBCS_INVALID = 4'hf
  } hbcs_stage_t;

  // Configuration method decoded from straps and data line
  typedef enum logic [2:0] {
    HBCS_M_SELF = 3'h0,
    HBCS_M_BUS_PWR = 3'h1,
    HBCS_M_EEPROM = 3'h3,
    HBCS_M_HOST = 3'h2,
    HBCS_M_BAD = 3'h6
  } hbcs_method_t;

  localparam logic [1:0] SEL_SELF = 2'h0;
  localparam logic [1:0] SEL_HOST = 2'h1;
  localparam logic [1:0] SEL_BUS_PWR = 2'h2;
  localparam logic [1:0] SEL_EEPROM = 2'h3;

  // Register address that ends host configuration
  localparam logic [7:0] CONFIG_DONE_TRIGGER = 8'hff;
  // Control register bits written by the host
  localparam logic [7:0] CTRL_REG = 8'h01;
  localparam int CTRL_KEEP_AWAKE = 0;
  localparam int CTRL_UP_CHG_EN = 1;
  localparam int CTRL_CHG_DET_EN = 2;
  localparam logic [7:0] CTRL_RESET = 8'h06;

  // Regulator settle and PLL lock wait, and detect line sample wait
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SENSE_NS = 200;
  localparam int SENSE_CYC = (SENSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // Decodes straps and data line into a method
  function automatic hbcs_method_t hbcs_decode(input logic [1:0] sel, input logic sda);
    hbcs_method_t m;
    m = HBCS_M_BAD;
    unique case (sel)
      SEL_SELF: m = HBCS_M_SELF;
      SEL_BUS_PWR: m = HBCS_M_BUS_PWR;
      SEL_EEPROM: m = sda ? HBCS_M_EEPROM : HBCS_M_BAD;
      SEL_HOST: m = sda ? HBCS_M_HOST : HBCS_M_BAD;
    endcase
    return m;
  endfunction

endpackage

/* logic/hbcs_if.sv */
// Interface joining the sequencer and the external host on the serial bus.
// Assumes the bench resolves the open-drain lines from the enables.
`timescale 1ns/100ps
interface hbcs_if;
  // Data and clock line levels seen by both ends
  logic sdaIn;
  logic sclIn;
  // Device weak pull-downs
  logic devSdaPullOe;
  logic devSclPullOe;
  // Host pull-ups fitted on the board
  logic hostPullUpOe;
  // Register write from host, one-cycle pulse
  logic wrValid;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  // Device accepts the write this cycle
  logic wrAck;
  // Device serves the bus
  logic busReady;

  modport device (
    input sdaIn, sclIn, wrValid, wrAddr, wrData,
    output devSdaPullOe, devSclPullOe, wrAck, busReady
  );
  modport host (
    input sdaIn, sclIn, wrAck, busReady,
    output hostPullUpOe, wrValid, wrAddr, wrData
  );
endinterface

/* logic/hbcs_host.sv */
// External host processor end: fits pull-ups and writes configuration.
// Assumes the user side issues one write request at a time.
`timescale 1ns/100ps
module hbcs_host
  import hbcs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic pullUpFitted,
  input wire logic reqValid,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic reqReady,
  output logic reqDone,
  hbcs_if.host bus
);

  // ----------------------------------------
  // Write issue
  // ----------------------------------------
  logic pending;

  // Board pull-ups let the device see a bus
  assign bus.hostPullUpOe = pullUpFitted; // RULE7
  // Only issue while the device serves the bus
  assign reqReady = !pending && bus.busReady; // RULE4 RULE17

  // Holds one write until the device takes it or stops serving the bus
  always_ff @(posedge mclk) begin
    if (srst) begin
      pending <= 1'b0;
      bus.wrValid <= 1'b0;
      bus.wrAddr <= 8'h00;
      bus.wrData <= 8'h00;
      reqDone <= 1'b0;
    end else if (clkEn) begin
      reqDone <= 1'b0;
      if (pending) begin
        if (bus.wrAck || !bus.busReady) begin
          pending <= 1'b0;
          bus.wrValid <= 1'b0;
          reqDone <= bus.wrAck;
        end
      end else if (reqValid && bus.busReady) begin
        pending <= 1'b1;
        bus.wrValid <= 1'b1;
        bus.wrAddr <= reqAddr; // RULE8
        bus.wrData <= reqData;
      end
    end
  end

endmodule

/* dv/hbcs_asserts.sv */
// Checker: boot stage and host bus relations over time.
// Assumes one clock mclk and a synchronous active-high srst.
`timescale 1ns/100ps
module hbcs_asserts
  import hbcs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic resetInN,
  input wire logic refClkPresent,
  input wire logic softDisconnect,
  input wire hbcs_stage_t stage,
  input wire logic regulatorOn,
  input wire logic pllRun,
  input wire logic sdaIn,
  input wire logic sclIn,
  input wire logic wrValid,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic wrAck,
  input wire logic busReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ----------------
  // Stage and bus write checks
  // ----------------
  a_standby_power_off: assert property ((!resetInN) [*3] |-> stage == HBCS_STANDBY && !regulatorOn && !pllRun)
    else $error("standby with power on");
  a_init_no_service: assert property (stage inside {HBCS_STANDBY, HBCS_HARDWARE_INIT_STAGE, HBCS_FW_INIT} |-> !busReady)
    else $error("bus served during init");
  a_ref_before_fw: assert property ((stage == HBCS_HARDWARE_INIT_STAGE && !refClkPresent) |=> stage != HBCS_FW_INIT)
    else $error("init left without reference clock");
  a_fw_after_power: assert property ((stage == HBCS_FW_INIT && $past(stage) == HBCS_HARDWARE_INIT_STAGE)
    |-> $past(regulatorOn && pllRun))
    else $error("init left before power up");
  a_bus_seen_ext: assert property ((stage == HBCS_EXT_SETUP && $past(stage) == HBCS_FW_INIT)
    |-> $past(sdaIn && sclIn))
    else $error("external setup without pull-ups");
  a_ext_no_timeout: assert property ((stage == HBCS_EXT_SETUP && !wrAck && resetInN)
    |=> stage == HBCS_EXT_SETUP)
    else $error("external setup left early");
  a_done_ends_ext: assert property ((stage == HBCS_EXT_SETUP && wrAck && resetInN
    && wrAddr == CONFIG_DONE_TRIGGER) |=> stage == HBCS_MERGE)
    else $error("done write not honoured");
  a_write_stands: assert property ((wrValid && wrAck) |=> !wrValid && $stable(wrAddr) && $stable(wrData))
    else $error("write taken twice or changed");
  a_soft_disc_hold: assert property ((softDisconnect && stage == HBCS_ATTACH && resetInN)
    |=> stage == HBCS_ATTACH)
    else $error("attach left during soft disconnect");
  // Main scenarios reached
  c_ext_done: cover property (stage == HBCS_EXT_SETUP ##1 stage == HBCS_MERGE);
  c_chg_det: cover property (stage == HBCS_CHG_DET);
  c_invalid: cover property (stage == HBCS_INVALID);
endmodule

/* dv/tb_top.sv */
// Bench: sequencer and host end joined by the interface.
// Assumes board pull-ups beat the weak pull-downs on both lines.
`timescale 1ns/100ps
module tb_top;
  import hbcs_pkg::*;
  logic mclk, srst, resetInN, refClkPresent, vbusDetect, softDisconnect, usbSuspend;
  logic clkEn, attachRequest;
  logic chgDetDone, eepromDone, pullUpFitted, reqValid, reqReady, reqDone, sawChg;
  logic regulatorOn, pllRun, selfPowered, eepromLoad, chgDetStart;
  logic [1:0] cfgSel;
  logic [7:0] reqAddr, reqData, appliedCtrl;
  hbcs_stage_t stage;
  int n_errors = 0, check_count = 0, modelCtrl;
  hbcs_if bus ();
  // Resolved line levels
  assign bus.sdaIn = bus.hostPullUpOe;
  assign bus.sclIn = bus.hostPullUpOe;
  hbcs_device hbcs_device_inst (.mclk(mclk), .srst(srst), .clkEn(clkEn), .resetInN(resetInN),
    .refClkPresent(refClkPresent), .cfgSel(cfgSel), .vbusDetect(vbusDetect), .attachRequest(attachRequest),
    .softDisconnect(softDisconnect), .usbSuspend(usbSuspend), .chgDetDone(chgDetDone), .eepromDone(eepromDone),
    .bus(bus.device), .stage(stage), .regulatorOn(regulatorOn), .pllRun(pllRun), .selfPowered(selfPowered),
    .eepromLoad(eepromLoad), .chgDetStart(chgDetStart), .appliedCtrl(appliedCtrl));
  hbcs_host hbcs_host_inst (.mclk(mclk), .srst(srst), .clkEn(clkEn), .pullUpFitted(pullUpFitted),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .reqDone(reqDone),
    .bus(bus.host));
  hbcs_asserts hbcs_asserts_inst (.mclk(mclk), .srst(srst), .resetInN(resetInN), .refClkPresent(refClkPresent),
    .softDisconnect(softDisconnect), .stage(stage), .regulatorOn(regulatorOn), .pllRun(pllRun),
    .sdaIn(bus.sdaIn), .sclIn(bus.sclIn), .wrValid(bus.wrValid), .wrAddr(bus.wrAddr), .wrData(bus.wrData),
    .wrAck(bus.wrAck), .busReady(bus.busReady));
  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a stage, noting charger detect
  task automatic waitStage(input hbcs_stage_t s);
    int n;
    n = 0;
    while (stage !== s && n < 4000) begin
      @(negedge mclk);
      if (stage === HBCS_CHG_DET) sawChg = 1'b1;
      n++;
    end
    chk({4'h0, stage}, {4'h0, s});
  endtask
  // Host write; model keeps the control byte
  task automatic hostWrite(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge mclk);
    reqValid = 1;
    reqAddr = a;
    reqData = d;
    #1;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (a == CTRL_REG && stage === HBCS_EXT_SETUP) modelCtrl = d;
    else if (a == CTRL_REG && stage !== HBCS_SUSPEND) modelCtrl = (modelCtrl & 6) | (d & 1);
    @(negedge mclk);
    reqValid = 0;
    n = 0;
    while (reqDone !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h0, reqDone}, 8'h01);
  endtask
  // Standby, new straps, then release without reference clock
  task automatic boot(input logic [1:0] sel, input logic pu);
    @(negedge mclk);
    resetInN = 0;
    refClkPresent = 0;
    repeat (4) @(negedge mclk);
    waitStage(HBCS_STANDBY);
    chk({6'h0, regulatorOn, pllRun}, 8'h00);
    {vbusDetect, usbSuspend, softDisconnect, chgDetDone, eepromDone, sawChg, attachRequest} = '0;
    cfgSel = sel;
    pullUpFitted = pu;
    modelCtrl = CTRL_RESET;
    resetInN = 1;
    repeat (2 * SETTLE_CYC) @(negedge mclk);
    waitStage(HBCS_HARDWARE_INIT_STAGE);
    refClkPresent = 1;
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h19b6));
    {resetInN, refClkPresent, cfgSel, vbusDetect, softDisconnect, usbSuspend, chgDetDone} = '0;
    {eepromDone, pullUpFitted, reqValid, reqAddr, reqData, sawChg, attachRequest} = '0;
    clkEn = 1;
    srst = 1;
    repeat (20) @(negedge mclk);
    srst = 0;
    // Self powered, no bus: defaults, charger detect, soft disconnect
    boot(2'h0, 1'b0);
    waitStage(HBCS_FW_INIT);
    @(negedge mclk);
    chk({6'h0, bus.devSdaPullOe, bus.devSclPullOe}, 8'h03);
    waitStage(HBCS_SUSPEND);
    chk(appliedCtrl, 8'(modelCtrl));
    chk({7'h0, selfPowered}, 8'h01);
    // Low clock enable holds the stage
    clkEn = 0;
    vbusDetect = 1;
    repeat (10) @(negedge mclk);
    chk({4'h0, stage}, {4'h0, HBCS_SUSPEND});
    clkEn = 1;
    waitStage(HBCS_CHG_DET);
    @(negedge mclk);
    chk({7'h0, chgDetStart}, 8'h01);
    chgDetDone = 1;
    waitStage(HBCS_NORMAL);
    @(negedge mclk);
    softDisconnect = 1;
    repeat (30) @(negedge mclk);
    waitStage(HBCS_ATTACH);
    @(negedge mclk);
    softDisconnect = 0;
    waitStage(HBCS_NORMAL);
    // Bus powered, invalid and EEPROM selections
    boot(2'h2, 1'b0);
    waitStage(HBCS_SUSPEND);
    chk({7'h0, selfPowered}, 8'h00);
    attachRequest = 1;
    waitStage(HBCS_CHG_DET);
    boot(2'h1, 1'b0);
    waitStage(HBCS_INVALID);
    boot(2'h3, 1'b1);
    waitStage(HBCS_MERGE);
    chk({7'h0, eepromLoad}, 8'h01);
    @(negedge mclk);
    eepromDone = 1;
    waitStage(HBCS_SUSPEND);
    // Host setup: no timeout, charging off, keep-awake after attach
    boot(2'h1, 1'b1);
    waitStage(HBCS_EXT_SETUP);
    repeat (3000) @(negedge mclk);
    waitStage(HBCS_EXT_SETUP);
    hostWrite(8'($urandom_range(32'hfe, 32'h02)), 8'($urandom));
    hostWrite(CTRL_REG, 8'h00);
    hostWrite(CONFIG_DONE_TRIGGER, 8'($urandom));
    waitStage(HBCS_SUSPEND);
    chk(appliedCtrl, 8'(modelCtrl));
    vbusDetect = 1;
    waitStage(HBCS_NORMAL);
    chk({7'h0, sawChg}, 8'h00);
    hostWrite(CTRL_REG, 8'h07);
    @(negedge mclk);
    // Settings applied at merge stand; keep-awake is not re-applied
    chk(appliedCtrl, 8'(modelCtrl & 6));
    {usbSuspend, vbusDetect} = 2'h2;
    waitStage(HBCS_SUSPEND);
    chk({7'h0, bus.busReady}, 8'h01);
    // Straps self powered with bus: detect disabled
    boot(2'h0, 1'b1);
    waitStage(HBCS_EXT_SETUP);
    hostWrite(CTRL_REG, 8'h02);
    hostWrite(CONFIG_DONE_TRIGGER, 8'h00);
    waitStage(HBCS_SUSPEND);
    vbusDetect = 1;
    waitStage(HBCS_NORMAL);
    chk({7'h0, sawChg}, 8'h01);
    {usbSuspend, vbusDetect} = 2'h2;
    waitStage(HBCS_SUSPEND);
    chk({7'h0, bus.busReady}, 8'h00);
    boot(2'h0, 1'b0);
    complete_run();
  end
endmodule
